//--- tb/scmc_checker.sv
/*
  Checker for the mode controller top: timing relations between load, init and user outputs.
  Assumes it is bound to scmc_top and sees only its ports.
*/
module scmc_checker #(
  parameter int unsigned RECFG_MAX_CYC = 2000
) (
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       reconfig_n_in,
  input wire logic [1:0] scheme_in,
  input wire logic       chain_enable_out_n,
  input wire logic       mem_select_out,
  input wire logic       load_busy_out,
  input wire logic       load_done_out,
  input wire logic       user_rst_out,
  input wire logic       user_io_oe_out,
  input wire logic       user_mode_out,
  input wire logic       timeout_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [31:0] cmd_cnt;
  logic        rcfg_q;
  // Cycles outside user mode since reset or the last reconfigure edge; the watchdog must bound these.
  always_ff @(posedge sys_clk_in) begin
    rcfg_q  <= sys_rst_in ? 1'b1 : reconfig_n_in;
    cmd_cnt <= (sys_rst_in || user_mode_out || (rcfg_q && !reconfig_n_in)) ?
               32'h0000_0000 : cmd_cnt + 32'h0000_0001;
  end
  a_load_io_off: assert property (load_busy_out |-> !user_io_oe_out && user_rst_out) else $error("io on in load");
  a_init_io_on: assert property ($rose(load_done_out) |-> !user_io_oe_out ##[3:5] user_io_oe_out)
    else $error("io enable late");
  a_init_user: assert property ($rose(user_io_oe_out) |-> user_rst_out ##[3:5] (!user_rst_out && user_mode_out))
    else $error("user start late");
  a_user_state: assert property (user_mode_out |-> user_io_oe_out && !user_rst_out) else $error("bad user mode");
  a_chain_done: assert property ($fell(chain_enable_out_n) |-> load_done_out) else $error("chain out early");
  a_reconfig_cmd: assert property ($fell(reconfig_n_in) |-> ##[1:3] (!user_mode_out && chain_enable_out_n))
    else $error("no return to command");
  a_mem_scheme: assert property (mem_select_out |-> $past(scheme_in) == scmc_pkg::SCHEME_MEMORY)
    else $error("memory select wrong");
  a_watchdog_fire: assert property (cmd_cnt > RECFG_MAX_CYC + 2 |-> timeout_out) else $error("no timeout");
  c_user: cover property ($rose(user_mode_out));
  c_mem: cover property ($rose(mem_select_out));
  c_reconf: cover property ($fell(reconfig_n_in) && user_mode_out);
  c_timeout: cover property ($rose(timeout_out));
endmodule

bind scmc_top scmc_checker #(.RECFG_MAX_CYC(RECFG_MAX_CYC)) scmc_checker_inst (.*);

//--- tb/scmc_src.sv
/*
  Model of the serial data source: memory or host, clocked or unclocked.
  Assumes the bench calls send and that inputs are sampled on the rising edge.
*/
module scmc_src (
  input  wire logic sys_clk_in,
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_start_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The serial clock stands still low between frames.
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_start_n_out = 1'b1;
  end
  // Words go LSB first; the unclocked scheme holds each bit for 8 cycles after a start low.
  task automatic send(input logic [1:0] scheme, input logic [63:0] img);
    for (int w = 0; w < 8; w++) begin
      if (scheme == scmc_pkg::SCHEME_UNCLOCKED) begin
        @(negedge sys_clk_in) ser_start_n_out <= 1'b0;
        @(negedge sys_clk_in) ser_start_n_out <= 1'b1;
      end
      for (int b = 0; b < 8; b++) begin
        @(negedge sys_clk_in) ser_data_out <= img[8*w+b];
        if (scheme == scmc_pkg::SCHEME_UNCLOCKED) begin
          repeat (7) @(negedge sys_clk_in);
        end else begin
          @(negedge sys_clk_in) ser_clk_out <= 1'b1;
          @(negedge sys_clk_in) ser_clk_out <= 1'b0;
        end
      end
    end
    // A released line shows the inverse of its last bit, never a held value.
    @(negedge sys_clk_in) ser_data_out <= ~ser_data_out;
  endtask
endmodule

//--- tb/scmc_top_tb.sv
/*
  Self-checking bench for the mode controller: loads in every scheme, chain gating,
  reconfiguration and the watchdog.
  Assumes the source model and the checker are compiled alongside.
*/
module scmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MAXC = 2000;
  logic sys_clk_in, sys_rst_in, reconfig_n_in, chain_enable_in_n;
  logic ser_clk_in, ser_data_in, ser_start_n_in;
  logic chain_enable_out_n, mem_select_out, load_busy_out, load_done_out;
  logic user_rst_out, user_io_oe_out, user_mode_out, timeout_out;
  logic [1:0]  scheme_in;
  logic [63:0] cfg_image_out, img;
  logic        mem_seen;
  int          error_cnt, checks;
  scmc_top #(.RECFG_MAX_CYC(MAXC)) scmc_top_inst (.*);
  scmc_src scmc_src_inst (.sys_clk_in(sys_clk_in), .ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in),
                          .ser_start_n_out(ser_start_n_in));
  // Clock at 25 MHz.
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected status of a finished load, worked out from the image that the model sent.
  task automatic expect_user(input logic [63:0] exp_img);
    int n;
    n = 0;
    while (load_done_out !== 1'b1 && n < 3000) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 3000) begin
      chk(1'b0, 1'b1);
      final_report();
    end
    chk(user_io_oe_out, 1'b0);
    chk(chain_enable_out_n, 1'b0);
    repeat (12) @(negedge sys_clk_in);
    chk({user_mode_out, user_io_oe_out, user_rst_out}, 3'b110);
    chk(cfg_image_out, exp_img);
    chk(timeout_out, 1'b0);
  endtask
  // The far side pulls the reconfigure pin low for two cycles.
  task automatic reconfig(input logic [1:0] s);
    @(negedge sys_clk_in) scheme_in <= s;
    reconfig_n_in <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
    reconfig_n_in <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    chk({user_mode_out, load_done_out, chain_enable_out_n, user_rst_out}, 4'b0011);
  endtask
  // Remembers that the memory scheme raised its select at least once since reset.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) mem_seen <= 1'b0;
    else if (mem_select_out === 1'b1) mem_seen <= 1'b1;
  end
  initial begin
    {reconfig_n_in, chain_enable_in_n, sys_rst_in} = 3'b101;
    scheme_in = scmc_pkg::SCHEME_MEMORY;
    error_cnt = 0;
    checks = 0;
    void'($urandom(99222));
    repeat (6) @(negedge sys_clk_in);
    chk({chain_enable_out_n, user_rst_out, user_io_oe_out, user_mode_out}, 4'b1100);
    sys_rst_in <= 1'b0;
    $display("test reset done");
    // Each scheme loads a fresh random image and reaches user mode.
    for (int s = 0; s < 3; s++) begin
      if (s > 0) reconfig(s[1:0]);
      img = {$urandom, $urandom};
      scmc_src_inst.send(s[1:0], img);
      expect_user(img);
      $display("test scheme %0d done", s);
    end
    chk(mem_seen, 1'b1);
    // A device not yet chained in ignores the data it sees.
    reconfig(scmc_pkg::SCHEME_CLOCKED);
    chain_enable_in_n <= 1'b1;
    scmc_src_inst.send(scmc_pkg::SCHEME_CLOCKED, ~img);
    chk({load_done_out, chain_enable_out_n, load_busy_out}, 3'b011);
    chain_enable_in_n <= 1'b0;
    img = {$urandom, $urandom};
    scmc_src_inst.send(scmc_pkg::SCHEME_CLOCKED, img);
    expect_user(img);
    $display("test chain done");
    // A reconfiguration that never completes is flagged by the watchdog.
    reconfig(2'h3);
    repeat (MAXC + 50) @(negedge sys_clk_in);
    chk({timeout_out, user_mode_out, user_io_oe_out}, 3'b100);
    $display("test watchdog done");
    final_report();
  end
endmodule

//--- verilog/scmc_deser.sv
/*
  Serial front end: takes one data bit per scheme-specific strobe and packs
  bits LSB first into words for the FIFO.
  Assumes all inputs synchronous to the system clock; the serial clock is an
  ordinary sampled input and is edge-detected here.
*/
module scmc_deser #(
  parameter int unsigned WORD_W  = 8,
  parameter int unsigned BIT_CYC = 8
) (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              enable_in,
  input  wire logic [1:0]        scheme_in,
  input  wire logic              ser_clk_in,
  input  wire logic              ser_data_in,
  input  wire logic              ser_start_n_in,
  output logic [WORD_W-1:0]      word_out,
  output logic                   word_valid_out,
  input  wire logic              word_ready_in,
  output logic                   stall_out
);

  localparam int unsigned BW = $clog2(WORD_W) + 1;
  localparam int unsigned CW = $clog2(BIT_CYC) + 1;

  typedef struct packed {
    logic              clk_d;
    logic [WORD_W-1:0] shift;
    logic [BW-1:0]     nbits;
    logic              busy;
    logic [CW-1:0]     tick;
  } scmc_deser_state_t;

  scmc_deser_state_t st;
  scmc_deser_state_t next_st;
  logic              strobe;

  assign word_out       = st.shift;
  assign word_valid_out = (st.nbits == BW'(WORD_W));
  assign stall_out      = word_valid_out && !word_ready_in;

  // Strobe choice: the clocked schemes shift on a rising serial clock, the
  // unclocked one on a bit-time counter started by a low start bit.
  always_comb begin
    next_st       = st;
    next_st.clk_d = ser_clk_in;
    strobe        = 1'b0;
    if (scheme_in == scmc_pkg::SCHEME_UNCLOCKED) begin
      if (!st.busy) begin
        if (enable_in && !ser_start_n_in) begin
          next_st.busy = 1'b1;
          next_st.tick = '0;
        end
      end else if (st.tick == CW'(BIT_CYC - 1)) begin
        next_st.tick = '0;
        strobe       = 1'b1;
      end else begin
        next_st.tick = st.tick + CW'(1);
      end
    end else begin
      strobe = ser_clk_in && !st.clk_d;
    end
    // A full word blocks further bits until the FIFO takes it.
    if (word_valid_out && word_ready_in) begin
      next_st.nbits = '0;
    end
    if (strobe && enable_in && !word_valid_out) begin
      next_st.shift = {ser_data_in, st.shift[WORD_W-1:1]};
      next_st.nbits = st.nbits + BW'(1);
      if (st.nbits == BW'(WORD_W - 1)) begin
        next_st.busy = 1'b0;
      end
    end
    if (!enable_in) begin
      next_st.nbits = '0;
      next_st.busy  = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

//--- verilog/scmc_fifo.sv
/*
  Synchronous FIFO between the serial deserialiser and configuration storage.
  Assumes one clock; writes are refused while full, reads while empty.
*/
module scmc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             sys_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             flush_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } scmc_fifo_state_t;

  scmc_fifo_state_t st;
  scmc_fifo_state_t next_st;
  logic             do_wr;
  logic             do_rd;

  // Honest flags straight from the occupancy count.
  assign wr_ready_out = (st.count != (AW+1)'(DEPTH));
  assign rd_valid_out = (st.count != '0);
  assign rd_data_out  = st.mem[st.rptr];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  // Pointer and count update; a flush empties the buffer for a new load.
  always_comb begin
    next_st = st;
    if (do_wr) begin
      next_st.mem[st.wptr] = wr_data_in;
      next_st.wptr         = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + AW'(1);
    end
    if (do_rd) begin
      next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + AW'(1);
    end
    next_st.count = st.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (flush_in) begin
      next_st.wptr  = '0;
      next_st.rptr  = '0;
      next_st.count = '0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

//--- verilog/scmc_pkg.sv
/*
  Package for the configuration mode controller: mode states, load scheme
  encodings, frame sizes and timing counts.
  Assumes a single 25 MHz system clock and a synchronous active-high reset.
*/
package scmc_pkg;

  // System clock rate and the derived reconfiguration budget.
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned RECFG_MAX_MS    = 100;
  localparam int unsigned RECFG_MAX_CYC   = (CLK_HZ / 1000) * RECFG_MAX_MS;

  // Length of the initialization phase in cycles (register reset, then I/O enable).
  localparam int unsigned INIT_RST_CYC    = 4;
  localparam int unsigned INIT_IO_CYC     = 4;

  // Configuration image size in bits; a small default keeps simulations short.
  localparam int unsigned CFG_BITS        = 64;
  localparam int unsigned CFG_WORD_W      = 8;
  localparam int unsigned FIFO_DEPTH      = 32;

  // Cycles per bit in the unclocked serial scheme, sampled at the end of each bit time counted from the start low.
  localparam int unsigned ASYNC_BIT_CYC   = 8;

  // Loading scheme selection.
  localparam logic [1:0] SCHEME_MEMORY    = 2'h0;
  localparam logic [1:0] SCHEME_CLOCKED   = 2'h1;
  localparam logic [1:0] SCHEME_UNCLOCKED = 2'h2;

  // Top-level mode states, one-hot.
  typedef enum logic [4:0] {
    SCMC_POWERUP = 5'b0_0001,
    SCMC_LOAD    = 5'b0_0010,
    SCMC_INITRST = 5'b0_0100,
    SCMC_INITIO  = 5'b0_1000,
    SCMC_USER    = 5'b1_0000
  } scmc_mode_t;

endpackage

//--- verilog/scmc_top.sv
/*
  Configuration mode controller: power-up load, initialization and user mode,
  pin-forced reconfiguration and chain enable hand-off.
  Assumes all pins synchronous to sys_clk_in; the user logic and I/O pads sit
  outside and obey the reset, enable and output-enable levels given here.
  The image is not checked for errors: a bad word
  still leads to user mode, and guarding against
  that is left to whatever produced the image.
  A much shorter reconfiguration budget may be set
  for simulation through the watchdog parameter.
  Scheme pins are expected to stay put during a load.
*/
// Operation
// (R1) Storage is volatile, so every reset starts in command mode and user mode needs a fresh full load.
// (R2) Right after loading, an initialization phase resets user registers, then enables I/O, then runs.
// (R3) All I/O stays high impedance from power-up through loading and is driven only after initialization; the code drives it from the I/O-enable phase on.
// (R4) There are two top-level modes: command mode (load and initialize) and user mode.
// (R5) A low pulse on the reconfigure pin returns the device to command mode for a new load and restart.
// (R6) A full reconfiguration must finish under 100 ms, and a watchdog flags an overrun.
// (R7) Three load schemes are supported: serial memory, clocked serial and unclocked serial.
// (R8) Devices chain by wiring each chain enable output to the next device's chain enable input.
// (R9) Data is ignored while chain enable input is high, and chain enable output goes low once loading ends.
// (R10) In command mode user registers stay in reset and user outputs are blocked until initialization ends; the code enables them in the I/O-enable phase.
module scmc_top #(
  parameter int unsigned CFG_BITS      = scmc_pkg::CFG_BITS,
  parameter int unsigned WORD_W        = scmc_pkg::CFG_WORD_W,
  parameter int unsigned DEPTH         = scmc_pkg::FIFO_DEPTH,
  parameter int unsigned RECFG_MAX_CYC = scmc_pkg::RECFG_MAX_CYC
) (
  input  wire logic                sys_clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                reconfig_n_in,
  input  wire logic [1:0]          scheme_in,
  input  wire logic                chain_enable_in_n,
  input  wire logic                ser_clk_in,
  input  wire logic                ser_data_in,
  input  wire logic                ser_start_n_in,
  output logic                     chain_enable_out_n,
  output logic                     mem_select_out,
  output logic                     load_busy_out,
  output logic                     load_done_out,
  output logic                     user_rst_out,
  output logic                     user_io_oe_out,
  output logic                     user_mode_out,
  output logic                     timeout_out,
  output logic [CFG_BITS-1:0]      cfg_image_out
);

  // NW is the number of words in one image.
  // The word counter and the watchdog carry a
  // spare bit, so each can hold its end value
  // and compare against it without wrapping.
  // IW only has to reach the longer init phase.
  localparam int unsigned NW  = CFG_BITS / WORD_W;
  localparam int unsigned WCW = $clog2(NW) + 1;
  localparam int unsigned TW  = $clog2(RECFG_MAX_CYC) + 1;
  localparam int unsigned IW  = 4;

  // Whole controller state in one record. The
  // mode steers everything else; the image keeps
  // words in arrival order, word 0 lowest; the
  // counters time the load, the init phases and
  // the watchdog. The single bits other than rcfg_d are registered
  // copies of the outputs, so no pin can glitch.
  typedef struct packed {
    scmc_pkg::scmc_mode_t   mode;
    logic [NW-1:0][WORD_W-1:0] image;
    logic [WCW-1:0]         nwords;
    logic [IW-1:0]          init_cnt;
    logic [TW-1:0]          wdog;
    logic                   rcfg_d;
    logic                   chain_out_n;
    logic                   mem_sel;
    logic                   busy;
    logic                   done;
    logic                   urst;
    logic                   ioe;
    logic                   umode;
    logic                   tout;
  } scmc_top_state_t;

  // Only the register process writes st, and
  // only the sequencer writes next_st.
  scmc_top_state_t st;
  scmc_top_state_t next_st;

  // Stream from the front end through the FIFO
  // to the image store. Ready flows backwards,
  // so a stalled stage keeps its word, but bits
  // that reach a stalled front end are dropped.
  logic              ds_en;
  logic [WORD_W-1:0] ds_word;
  logic              ds_valid;
  logic              ds_ready;
  logic [WORD_W-1:0] ff_word;
  logic              ff_valid;
  logic              ff_ready;
  logic              flush;

  // Legal scheme codes. The fourth code loads
  // nothing on purpose, so that a host can park
  // a device in command mode.
  function automatic logic scheme_ok(input logic [1:0] s);
    scheme_ok = (s == scmc_pkg::SCHEME_MEMORY) || (s == scmc_pkg::SCHEME_CLOCKED) ||
                (s == scmc_pkg::SCHEME_UNCLOCKED);
  endfunction

  // Chain gating. While the chain enable input
  // is high it is not this device's turn: the
  // bits on the shared line belong to a device
  // further up the chain, so the front end is
  // held off and any partial word is dropped.
  // Bits flow only while loading and selected by the chain.
  assign ds_en    = (st.mode == scmc_pkg::SCMC_LOAD) && !chain_enable_in_n && scheme_ok(scheme_in); // R9
  assign flush    = (st.mode != scmc_pkg::SCMC_LOAD);
  assign ff_ready = (st.mode == scmc_pkg::SCMC_LOAD) && (st.nwords != WCW'(NW));

  // Serial front end. It sees the scheme pins
  // directly, so its strobe source follows them
  // at once. Changing the scheme mid-load spoils
  // the word in flight but cannot hang anything.
  scmc_deser #(
    .WORD_W  (WORD_W),
    .BIT_CYC (scmc_pkg::ASYNC_BIT_CYC)
  ) u_deser (
    .sys_clk_in     (sys_clk_in),
    .sys_rst_in     (sys_rst_in),
    .enable_in      (ds_en),
    .scheme_in      (scheme_in), // R7
    .ser_clk_in     (ser_clk_in),
    .ser_data_in    (ser_data_in),
    .ser_start_n_in (ser_start_n_in),
    .word_out       (ds_word),
    .word_valid_out (ds_valid),
    .word_ready_in  (ds_ready),
    .stall_out      ()
  );

  // Buffer between the bit rate and the store.
  // The store takes a word whenever it has room,
  // so this seldom holds more than one; but the
  // serial side cannot pause its sender, so the
  // front end must always find room at once.
  // It is flushed outside the load phase, so a
  // restarted load never sees stale words.
  scmc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .flush_in     (flush),
    .wr_data_in   (ds_word),
    .wr_valid_in  (ds_valid),
    .wr_ready_out (ds_ready),
    .rd_data_out  (ff_word),
    .rd_valid_out (ff_valid),
    .rd_ready_in  (ff_ready)
  );

  // Mode sequencer. Reset lands in power-up so nothing runs on stale storage.
  // A full copy of the record is taken first,
  // so every field holds unless a branch below
  // changes it, and no latch can creep in.
  always_comb begin
    next_st        = st;
    // Last pin level for the edge detect. It
    // resets to the idle level: no false edge.
    next_st.rcfg_d = reconfig_n_in;

    // Normal life runs down this case: power-up,
    // load, register reset, I/O enable, user.
    // The watchdog and the reconfigure edge come
    // after it, so they override its transitions.
    case (st.mode)
      // One cycle to clear the count and raise
      // busy; nothing stored earlier is trusted.
      scmc_pkg::SCMC_POWERUP: begin
        next_st.mode   = scmc_pkg::SCMC_LOAD; // R1
        next_st.nwords = '0;
        next_st.busy   = 1'b1;
        next_st.done   = 1'b0;
      end

      // Words are stored as they leave the FIFO.
      // When the last has landed, the chain output
      // falls and the next device may load.
      scmc_pkg::SCMC_LOAD: begin
        if (ff_valid && ff_ready) begin
          next_st.image[st.nwords[WCW-2:0]] = ff_word;
          next_st.nwords                    = st.nwords + WCW'(1);
        end
        // Decided on the registered count, one
        // cycle after the last word, which keeps
        // the compare off the FIFO read path.
        if (st.nwords == WCW'(NW)) begin
          next_st.mode        = scmc_pkg::SCMC_INITRST; // R2
          next_st.busy        = 1'b0;
          next_st.done        = 1'b1;
          next_st.chain_out_n = 1'b0; // R9 R8
          next_st.init_cnt    = '0;
        end
      end

      // First phase: registers in reset and I/O
      // tri-stated, so the logic starts from known
      // values before any pin can be driven.
      scmc_pkg::SCMC_INITRST: begin
        next_st.init_cnt = st.init_cnt + IW'(1);
        // Counted from zero, so the phase is exact.
        if (st.init_cnt == IW'(scmc_pkg::INIT_RST_CYC - 1)) begin
          next_st.mode     = scmc_pkg::SCMC_INITIO; // R2
          next_st.ioe      = 1'b1; // R3
          next_st.init_cnt = '0;
        end
      end

      // Second phase: pads are driven while the
      // registers are still in reset, so they
      // settle before the logic moves them.
      scmc_pkg::SCMC_INITIO: begin
        next_st.init_cnt = st.init_cnt + IW'(1);
        // Counted from zero, like the first phase.
        if (st.init_cnt == IW'(scmc_pkg::INIT_IO_CYC - 1)) begin
          next_st.mode  = scmc_pkg::SCMC_USER; // R4
          next_st.urst  = 1'b0; // R10
          next_st.umode = 1'b1;
          next_st.wdog  = '0;
        end
      end

      // Lasts until a reconfigure edge or reset.
      scmc_pkg::SCMC_USER: begin
        next_st.umode = 1'b1;
      end

      // An illegal code means an upset: reload.
      default: begin
        next_st.mode = scmc_pkg::SCMC_POWERUP;
      end
    endcase

    // Watchdog over a forced reconfiguration; stops once user mode is back.
    // It runs from reset too, so a missing or
    // stuck source is caught at power-up. The
    // flag is sticky until a reconfigure edge or
    // reset, so a slow host cannot miss it.
    if (st.mode != scmc_pkg::SCMC_USER && st.wdog != TW'(RECFG_MAX_CYC)) begin
      next_st.wdog = st.wdog + TW'(1);
    end
    if (st.wdog == TW'(RECFG_MAX_CYC) && st.mode != scmc_pkg::SCMC_USER) begin
      next_st.tout = 1'b1; // R6
    end

    // A falling edge of the reconfigure pin forces command mode from anywhere.
    // It sits last so that it wins over all of
    // the above. A request mid-word is harmless:
    // the partial word is dropped on the fresh
    // load. Only the edge acts, so holding the
    // pin low does not restart again and again.
    if (st.rcfg_d && !reconfig_n_in) begin
      next_st.mode        = scmc_pkg::SCMC_POWERUP; // R5
      next_st.urst        = 1'b1; // R10
      next_st.ioe         = 1'b0; // R3
      next_st.umode       = 1'b0; // R4
      next_st.chain_out_n = 1'b1;
      next_st.busy        = 1'b0;
      next_st.done        = 1'b0;
      next_st.wdog        = '0;
      next_st.tout        = 1'b0;
    end

    // Follows the next mode, so the select rises
    // in the cycle the load begins, not after.
    next_st.mem_sel = (next_st.mode == scmc_pkg::SCMC_LOAD) && !chain_enable_in_n &&
                      (scheme_in == scmc_pkg::SCHEME_MEMORY); // R7
  end

  // State register; reset values are safe command-mode levels.
  // A synchronous reset keeps the record in one
  // clock domain; the price is that the clock
  // must run while reset is held.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st             <= '0;
      st.mode        <= scmc_pkg::SCMC_POWERUP; // R1
      st.rcfg_d      <= 1'b1;
      st.chain_out_n <= 1'b1;
      st.urst        <= 1'b1; // R10
      st.ioe         <= 1'b0; // R3
    end else begin
      st <= next_st;
    end
  end

  // All outputs come straight from state flip-flops.
  // The pads and user logic outside rely on
  // that: a spike on the output enable would
  // briefly drive a shared net, and a spike on
  // the user reset would scramble registers.
  assign chain_enable_out_n = st.chain_out_n;
  assign mem_select_out     = st.mem_sel;
  assign load_busy_out      = st.busy;
  assign load_done_out      = st.done;
  assign user_rst_out       = st.urst;
  assign user_io_oe_out     = st.ioe;
  assign user_mode_out      = st.umode;
  assign timeout_out        = st.tout;
  assign cfg_image_out      = st.image;

endmodule
